// ---- src/msi_modem_status.sv ----
// msi_modem_status: modem status inputs of a serial port, with an ahb-lite register slave.
// assumes: a single ahb-lite master, word transfers only, one clock hclk at 40 MHz.
//
// How it works
// - status bit 7 reads the inverse of the synchronised carrier detect pin.
// - status bit 3 sets when carrier detect rises low to high since the last status read.
// - with enable bit 3 and mask bit 0 set, any carrier detect change raises the interrupt request.
// - status bit 5 reads the inverse of the synchronised data set ready pin.
// - status bit 1 sets when data set ready rises low to high since the last status read.
//
// Implementation choices: the AHB-Lite interface to the registers and the register addresses.

`timescale 1ns/1ps
`default_nettype none

module msi_modem_status
	import msi_pkg::*;
(
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	// modem pins
	input  wire logic        carrier_detect_n,
	input  wire logic        set_ready_n,
	input  wire logic        serial_data_in,
	// to the receiver and the interrupt controller
	output logic             serial_data_sync,
	output logic             irq
);

	// ==========================================================
	// pin synchronisation
	logic [MSI_SYNC_W-1:0] pins_async;
	logic [MSI_SYNC_W-1:0] pins_sync;

	// pins are packed in the order the package names them
	always_comb begin
		pins_async                   = MSI_SYNC_RESET;
		pins_async[MSI_SYNC_CARRIER] = carrier_detect_n;
		pins_async[MSI_SYNC_READY]   = set_ready_n;
		pins_async[MSI_SYNC_SERIAL]  = serial_data_in;
	end

	msi_sync u_sync (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.pins_async (pins_async),
		.pins_sync  (pins_sync)
	);

	assign serial_data_sync = pins_sync[MSI_SYNC_SERIAL];

	// ==========================================================
	// edge detection on the synchronised pins
	logic prev_carrier_n;
	logic prev_ready_n;
	logic next_prev_carrier_n;
	logic next_prev_ready_n;
	logic carrier_rise;
	logic ready_rise;
	logic carrier_change;
	logic ready_change;

	// previous levels follow the synchronised pins
	always_comb begin
		next_prev_carrier_n = pins_sync[MSI_SYNC_CARRIER];
		next_prev_ready_n   = pins_sync[MSI_SYNC_READY];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_carrier_n <= MSI_SYNC_RESET[MSI_SYNC_CARRIER];
			prev_ready_n   <= MSI_SYNC_RESET[MSI_SYNC_READY];
		end else begin
			prev_carrier_n <= next_prev_carrier_n;
			prev_ready_n   <= next_prev_ready_n;
		end
	end

	// a rise of the active-low pin is the modem dropping the signal
	assign carrier_rise   = pins_sync[MSI_SYNC_CARRIER] & ~prev_carrier_n;
	assign ready_rise     = pins_sync[MSI_SYNC_READY] & ~prev_ready_n;
	assign carrier_change = pins_sync[MSI_SYNC_CARRIER] ^ prev_carrier_n;
	assign ready_change   = pins_sync[MSI_SYNC_READY] ^ prev_ready_n;

	// ==========================================================
	// ahb-lite address phase decode
	logic       addr_take;
	logic       rd_take;
	logic [7:0] rd_ofs;
	logic       wr_pend;
	logic [7:0] wr_ofs;
	logic       next_wr_pend;
	logic [7:0] next_wr_ofs;

	// only bits 7:0 decode; the block is a small window selected by hsel
	assign addr_take = hsel & hready & htrans[MSI_HTRANS_ACTIVE_BIT];
	assign rd_take   = addr_take & ~hwrite;
	assign rd_ofs    = haddr[7:0];

	// a write is held until its data phase, where hwdata stands
	always_comb begin
		next_wr_pend = addr_take & hwrite;
		next_wr_ofs  = haddr[7:0];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_ofs  <= 8'h00;
		end else begin
			wr_pend <= next_wr_pend;
			wr_ofs  <= next_wr_ofs;
		end
	end

	// zero wait states, always okay; hsize is not checked since only words are used
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ==========================================================
	// event flags and software registers
	logic       carrier_delta;
	logic       ready_delta;
	logic [1:0] int_status;
	logic [1:0] int_mask;
	logic [7:0] int_enable;
	logic       next_carrier_delta;
	logic       next_ready_delta;
	logic [1:0] next_int_status;
	logic [1:0] next_int_mask;
	logic [7:0] next_int_enable;
	logic       msr_read;
	logic       ists_read;
	logic [1:0] change_set;

	assign msr_read  = rd_take & (rd_ofs == MSI_OFS_MODEM_STATUS);
	assign ists_read = rd_take & (rd_ofs == MSI_OFS_INT_STATUS);

	always_comb begin
		change_set                      = 2'h0;
		change_set[MSI_INT_CARRIER_BIT] = carrier_change;
		change_set[MSI_INT_READY_BIT]   = ready_change;
	end

	// a set in the same cycle as a clear wins, so no edge is lost
	always_comb begin
		next_carrier_delta = (carrier_delta & ~msr_read) | carrier_rise;
		next_ready_delta   = (ready_delta & ~msr_read) | ready_rise;
		next_int_status    = (int_status & ~{2{msr_read | ists_read}}) | change_set;
		next_int_mask      = int_mask;
		next_int_enable    = int_enable;
		if (wr_pend) begin
			if (wr_ofs == MSI_OFS_INT_ENABLE) begin
				next_int_enable = hwdata[7:0];
			end else if (wr_ofs == MSI_OFS_INT_MASK) begin
				next_int_mask = hwdata[1:0];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			carrier_delta <= 1'b0;
			ready_delta   <= 1'b0;
			int_status    <= MSI_FLAGS_RESET;
			int_mask      <= MSI_INT_MASK_RESET;
			int_enable    <= MSI_IER_RESET;
		end else begin
			carrier_delta <= next_carrier_delta;
			ready_delta   <= next_ready_delta;
			int_status    <= next_int_status;
			int_mask      <= next_int_mask;
			int_enable    <= next_int_enable;
		end
	end

	// ==========================================================
	// read data, registered at the address phase edge
	logic [31:0] rd_value;
	logic [31:0] next_hrdata;

	// the read value is taken before the read clears the deltas
	always_comb begin
		rd_value = 32'h0000_0000;
		if (rd_ofs == MSI_OFS_MODEM_STATUS) begin
			rd_value[MSI_MSR_CARRIER_BIT]       = ~pins_sync[MSI_SYNC_CARRIER];
			rd_value[MSI_MSR_READY_BIT]         = ~pins_sync[MSI_SYNC_READY];
			rd_value[MSI_MSR_CARRIER_DELTA_BIT] = carrier_delta;
			rd_value[MSI_MSR_READY_DELTA_BIT]   = ready_delta;
		end else if (rd_ofs == MSI_OFS_INT_ENABLE) begin
			rd_value[7:0] = int_enable;
		end else if (rd_ofs == MSI_OFS_INT_STATUS) begin
			rd_value[1:0] = int_status;
		end else if (rd_ofs == MSI_OFS_INT_MASK) begin
			rd_value[1:0] = int_mask;
		end else if (rd_ofs == MSI_OFS_LINE_LEVEL) begin
			rd_value[MSI_LVL_SERIAL_BIT] = pins_sync[MSI_SYNC_SERIAL];
		end
		next_hrdata = rd_take ? rd_value : 32'h0000_0000;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else begin
			hrdata <= next_hrdata;
		end
	end

	// ==========================================================
	// interrupt output: level, gated by the modem source enable and the mask
	logic next_irq;

	always_comb begin
		next_irq = int_enable[MSI_IER_MODEM_BIT] & (|(int_status & int_mask));
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= next_irq;
		end
	end

endmodule : msi_modem_status

`default_nettype wire

// ---- src/msi_pkg.sv ----
// msi_pkg: shared constants of the modem status input block.
// assumes: word-aligned 32-bit ahb-lite register access, 40 MHz hclk.

package msi_pkg;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] MSI_OFS_MODEM_STATUS = 8'h00;
	localparam logic [7:0] MSI_OFS_INT_ENABLE   = 8'h04;
	localparam logic [7:0] MSI_OFS_INT_STATUS   = 8'h08;
	localparam logic [7:0] MSI_OFS_INT_MASK     = 8'h0C;
	localparam logic [7:0] MSI_OFS_LINE_LEVEL   = 8'h10;

	// ==========================================================
	// modem status register field positions
	localparam int MSI_MSR_CARRIER_BIT       = 7;
	localparam int MSI_MSR_READY_BIT         = 5;
	localparam int MSI_MSR_CARRIER_DELTA_BIT = 3;
	localparam int MSI_MSR_READY_DELTA_BIT   = 1;

	// interrupt enable: modem status source enable
	localparam int MSI_IER_MODEM_BIT = 3;

	// interrupt status and mask layout
	localparam int MSI_INT_CARRIER_BIT = 0;
	localparam int MSI_INT_READY_BIT   = 1;

	// line level register layout
	localparam int MSI_LVL_SERIAL_BIT = 0;

	// ==========================================================
	// widths and reset values
	localparam int         MSI_SYNC_W         = 3;
	localparam int         MSI_SYNC_CARRIER   = 0;
	localparam int         MSI_SYNC_READY     = 1;
	localparam int         MSI_SYNC_SERIAL    = 2;
	localparam logic [2:0] MSI_SYNC_RESET     = 3'h7;
	localparam logic [7:0] MSI_IER_RESET      = 8'h00;
	localparam logic [1:0] MSI_INT_MASK_RESET = 2'h3;
	localparam logic [1:0] MSI_FLAGS_RESET    = 2'h0;

	// ahb transfer type bit that marks an active transfer
	localparam int MSI_HTRANS_ACTIVE_BIT = 1;

endpackage : msi_pkg

// ---- src/msi_sync.sv ----
// msi_sync: two flip-flop synchroniser for the asynchronous modem pins.
// assumes: pins idle high, so both stages reset to the idle level.

`timescale 1ns/1ps
`default_nettype none

module msi_sync
	import msi_pkg::*;
(
	// clock and reset
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	// asynchronous pins and their synchronised levels
	input  wire logic [MSI_SYNC_W-1:0] pins_async,
	output logic      [MSI_SYNC_W-1:0] pins_sync
);

	logic [MSI_SYNC_W-1:0] stage_one;
	logic [MSI_SYNC_W-1:0] stage_two;

	// ==========================================================
	// stage one is read only by stage two, to keep metastability contained
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stage_one <= MSI_SYNC_RESET;
			stage_two <= MSI_SYNC_RESET;
		end else begin
			stage_one <= pins_async;
			stage_two <= stage_one;
		end
	end

	assign pins_sync = stage_two;

endmodule : msi_sync

`default_nettype wire

// ---- verif/msi_modem_status_props.sv ----
// msi_modem_status_props: port-level checks of the modem status block.
// assumes: zero-wait slave with registered read data and 2-flop pin sync.
`timescale 1ns/1ps
`default_nettype none
module msi_modem_status_props
	import msi_pkg::*;
(
	// clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	// pins and outputs
	input wire logic        carrier_detect_n,
	input wire logic        set_ready_n,
	input wire logic        serial_data_in,
	input wire logic        serial_data_sync,
	input wire logic        irq
);
	logic       rd_any;
	logic       rd_msr;
	logic [1:0] prev;
	logic [3:0] quiet;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ==========================================================
	// helpers: decoded reads and cycles since the last pin change
	assign rd_any = hsel && hready && htrans[1] && !hwrite;
	assign rd_msr = rd_any && (haddr[7:0] == MSI_OFS_MODEM_STATUS);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev  <= 2'h3;
			quiet <= 4'h0;
		end else begin
			prev  <= {carrier_detect_n, set_ready_n};
			quiet <= (prev != {carrier_detect_n, set_ready_n}) ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
		end
	end
	// ==========================================================
	// assertions
	AST_NOWAIT: assert property (hreadyout && !hresp)
		else $error("slave not zero-wait okay");
	AST_IDLE_RDATA: assert property (!rd_any |=> hrdata == 32'h0)
		else $error("read data not zero outside a read");
	AST_CARRIER_LEVEL: assert property (rd_msr |=> hrdata[7] == !$past(carrier_detect_n, 3))
		else $error("carrier level bit wrong");
	AST_READY_LEVEL: assert property (rd_msr |=> hrdata[5] == !$past(set_ready_n, 3))
		else $error("ready level bit wrong");
	AST_CARRIER_DELTA: assert property ($rose(carrier_detect_n) ##3 rd_msr |=> hrdata[3])
		else $error("carrier delta not set");
	AST_READY_DELTA: assert property ($rose(set_ready_n) ##3 rd_msr |=> hrdata[1])
		else $error("ready delta not set");
	AST_DELTA_CLEAR: assert property (rd_msr ##3 (rd_msr && quiet >= 4'h7) |=> !hrdata[3] && !hrdata[1])
		else $error("delta bits survive a read");
	AST_IRQ_CLEAR: assert property (rd_msr && quiet >= 4'h8 |-> ##2 !irq)
		else $error("irq stays after status read");
	AST_SERIAL_SYNC: assert property (serial_data_sync == $past(serial_data_in, 2))
		else $error("serial sync delay wrong");
endmodule : msi_modem_status_props
bind msi_modem_status msi_modem_status_props u_props (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .carrier_detect_n(carrier_detect_n),
	.set_ready_n(set_ready_n), .serial_data_in(serial_data_in),
	.serial_data_sync(serial_data_sync), .irq(irq));
`default_nettype wire

// ---- verif/msi_modem_model.sv ----
// msi_modem_model: behavioural modem driving the handshake and data pins.
// assumes: the bench changes requested states just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module msi_modem_model (
	// requested modem states
	input  wire logic carrier_on,
	input  wire logic ready_on,
	input  wire logic line_bit,
	// pins to the serial port
	output logic      carrier_detect_n,
	output logic      set_ready_n,
	output logic      serial_data_in
);
	// pins are active low: a present carrier pulls its pin to 0
	assign carrier_detect_n = ~carrier_on;
	assign set_ready_n      = ~ready_on;
	assign serial_data_in   = line_bit;
endmodule : msi_modem_model
`default_nettype wire

// ---- verif/msi_modem_status_tb.sv ----
// msi_modem_status_tb: randomised bench for the modem status block.
// assumes: the dut is the only slave, so hready loops back from hreadyout.
`timescale 1ns/1ps
`default_nettype none
module msi_modem_status_tb;
	import msi_pkg::*;
	logic             hclk;
	logic             hresetn = 1'b0;
	logic             hsel    = 1'b0;
	logic             hwrite  = 1'b0;
	logic [1:0]       htrans  = 2'h0;
	logic [31:0]      haddr   = 32'h0;
	logic [31:0]      hwdata  = 32'h0;
	logic             cd      = 1'b0;
	logic             dr      = 1'b0;
	logic             ln      = 1'b1;
	logic             dc      = 1'b0;
	logic             dd      = 1'b0;
	logic             cc;
	logic             rc;
	logic [31:0]      r;
	wire logic [31:0] hrdata;
	wire logic        hreadyout, hresp, cd_n, sr_n, sdi, sds, irq;
	int               num_errors = 0;
	int               checks     = 0;
	// ==========================================================
	// partner and dut
	msi_modem_model u_modem (.carrier_on(cd), .ready_on(dr), .line_bit(ln),
		.carrier_detect_n(cd_n), .set_ready_n(sr_n), .serial_data_in(sdi));
	msi_modem_status dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .carrier_detect_n(cd_n),
		.set_ready_n(sr_n), .serial_data_in(sdi), .serial_data_sync(sds), .irq(irq));
	// ==========================================================
	// tasks: one single-word transfer, a compare, the verdict
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : bus
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask : chk
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : final_report
	// expected status word from the modelled pin states and deltas
	function automatic logic [31:0] msr_exp();
		msr_exp = 32'h0;
		msr_exp[MSI_MSR_CARRIER_BIT] = cd;
		msr_exp[MSI_MSR_READY_BIT] = dr;
		msr_exp[MSI_MSR_CARRIER_DELTA_BIT] = dc;
		msr_exp[MSI_MSR_READY_DELTA_BIT] = dd;
	endfunction : msr_exp
	// ==========================================================
	// clock and watchdog, sized well beyond the ~400 cycles used
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	initial begin
		#125000;
		num_errors++;
		$display("MISMATCH %0t watchdog expired before the tests ended", $time);
		final_report();
	end
	// ==========================================================
	// main sequence
	initial begin
		r = $urandom(31147);
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, MSI_OFS_INT_ENABLE, 32'h0);
		chk(r, {24'h0, MSI_IER_RESET}, "enable reset");
		bus(1'b0, MSI_OFS_INT_MASK, 32'h0);
		chk(r, {30'h0, MSI_INT_MASK_RESET}, "mask reset");
		bus(1'b0, MSI_OFS_MODEM_STATUS, 32'h0);
		chk(r, msr_exp(), "status reset");
		bus(1'b0, 8'h20, 32'h0);
		chk(r, 32'h0, "unmapped read");
		$display("test reset done");
		// a masked change must wait for the mask before reaching irq
		bus(1'b1, MSI_OFS_INT_ENABLE, 32'h8);
		bus(1'b1, MSI_OFS_INT_MASK, 32'h0);
		cd <= 1'b1;
		repeat (8) @(posedge hclk);
		chk(irq, 1'b0, "masked irq");
		bus(1'b1, MSI_OFS_INT_MASK, 32'h3);
		repeat (3) @(posedge hclk);
		chk(irq, 1'b1, "unmasked irq");
		bus(1'b0, MSI_OFS_MODEM_STATUS, 32'h0);
		chk(r, msr_exp(), "falling edge gives no delta");
		repeat (2) @(posedge hclk);
		chk(irq, 1'b0, "irq after read");
		$display("test mask done");
		// with the modem source disabled a change must stay off irq until enabled
		bus(1'b1, MSI_OFS_INT_ENABLE, 32'h0000_0000);
		dr <= 1'b1;
		repeat (8) @(posedge hclk);
		chk(irq, 1'b0, "disabled irq");
		bus(1'b1, MSI_OFS_INT_ENABLE, 32'h0000_0008);
		repeat (3) @(posedge hclk);
		chk(irq, 1'b1, "enabled irq");
		bus(1'b0, MSI_OFS_INT_ENABLE, 32'h0000_0000);
		chk(r, 32'h0000_0008, "enable readback");
		bus(1'b0, MSI_OFS_INT_STATUS, 32'h0000_0000);
		chk(r, 32'h0000_0001 << MSI_INT_READY_BIT, "ready change flag");
		bus(1'b0, MSI_OFS_INT_STATUS, 32'h0000_0000);
		chk(r, 32'h0000_0000, "change flag cleared by its read");
		bus(1'b0, MSI_OFS_MODEM_STATUS, 32'h0000_0000);
		chk(r, msr_exp(), "ready fall gives no delta");
		$display("test enable done");
		// random pin toggles; fast reads land right on the event edge
		for (int i = 0; i < 16; i++) begin
			r = $urandom;
			cc = r[0];
			rc = r[1];
			dc = cc & cd;
			dd = rc & dr;
			cd <= cd ^ cc;
			dr <= dr ^ rc;
			ln <= r[2];
			if (r[3]) begin
				repeat (2) @(posedge hclk);
				bus(1'b0, MSI_OFS_MODEM_STATUS, 32'h0);
			end else begin
				repeat (8) @(posedge hclk);
				chk(irq, cc | rc, "change irq");
				bus(1'b0, MSI_OFS_INT_STATUS, 32'h0);
				chk(r, {30'h0, rc, cc}, "change flags");
				bus(1'b0, MSI_OFS_MODEM_STATUS, 32'h0);
			end
			chk(r, msr_exp(), "status word");
			dc = 1'b0;
			dd = 1'b0;
			bus(1'b0, MSI_OFS_MODEM_STATUS, 32'h0);
			chk(r, msr_exp(), "status after read");
			chk(irq, 1'b0, "irq after read");
			bus(1'b0, MSI_OFS_LINE_LEVEL, 32'h0);
			chk(r, {31'h0, ln}, "line level");
		end
		$display("test random done");
		final_report();
	end
endmodule : msi_modem_status_tb
`default_nettype wire
